/* File: i2c_ack_bit_and_adapter_enable_tb_top.sv */
// self-checking bench of the ack bit and adapter enable block
`default_nettype none
module i2c_ack_bit_and_adapter_enable_tb_top
    import iaba_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, wr_stb, rd_stb, cmd_done, irq, s, a;
    logic scl_oe, sda_oe, m_scl, m_sda, scl_w, sda_w;
    logic [7:0] addr, wdata, rdata;
    logic pin_scl_o, pin_sda_o;
    logic [31:0] seed;
    int n_mismatch, n_checks;
    // open-drain wires: anyone pulling low wins
    assign scl_w = m_scl & ~scl_oe;
    assign sda_w = m_sda & ~sda_oe;
    iaba_top dut_u (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr_stb), .RD(rd_stb), .RDATA(rdata), .CMD_DONE(cmd_done),
        .IRQ(irq), .SCL_I(scl_w), .SCL_O(pin_scl_o), .SCL_OE(scl_oe),
        .SDA_I(sda_w), .SDA_O(pin_sda_o), .SDA_OE(sda_oe));
    iaba_bus_model bm_u (.clk(clk), .sda_i(sda_w), .scl_o(m_scl),
        .sda_o(m_sda));
    // 50 mhz clock
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    // expected status: byte flag, nack flag, ack bit
    function automatic logic [7:0] st_exp(input logic bf, nf, ak);
        return {bf, nf, 5'h00, ak};
    endfunction : st_exp
    task automatic chk(input string nm, input logic [7:0] e, g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ad, v);
        @(posedge clk);
        addr <= ad;
        wdata <= v;
        wr_stb <= 1'h1;
        @(posedge clk);
        wr_stb <= 1'h0;
        #1;
    endtask : wr
    // read data stand only in the cycle after the strobe edge
    task automatic rc(input logic [7:0] ad, e, input string nm);
        @(posedge clk);
        addr <= ad;
        rd_stb <= 1'h1;
        @(posedge clk);
        rd_stb <= 1'h0;
        #1;
        chk(nm, e, rdata);
    endtask : rc
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    // watchdog: the whole sequence needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end
    initial begin
        rst_n = 1'h0;
        {wr_stb, rd_stb, cmd_done} = 3'h0;
        {addr, wdata} = 16'h0000;
        seed = 32'hcb4f;
        n_mismatch = 0;
        n_checks = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        for (int i = 0; i < 6; i++) rc(i[7:0], REG_RST, "reset");
        rc(8'h3c, 8'h00, "unmapped");
        wr(ADDR_ADAPT, 8'hc0);
        rc(ADDR_ADAPT, 8'hc0, "adapter rw");
        wr(ADDR_ADAPT, 8'h00);
        // software ack survives a switch to transmit and back
        wr(ADDR_STATUS, 8'h01);
        wr(ADDR_CTRL, 8'h91);
        rc(ADDR_STATUS, 8'h00, "tx read");
        wr(ADDR_CTRL, 8'h80);
        rc(ADDR_STATUS, 8'h01, "rx read");
        // receive: random bytes and random ack values
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            a = seed[8];
            wr(ADDR_STATUS, {7'h00, a});
            bm_u.frame(seed[7:0], 1'h1, s);
            chk("rx ack", {7'h00, a}, {7'h00, s});
            rc(ADDR_STATUS, st_exp(1'h1, 1'h0, a), "rx st");
            wr(ADDR_STATUS, 8'hc0 | {7'h00, a});
            rc(ADDR_STATUS, st_exp(1'h1, 1'h0, a), "w1 flag");
            wr(ADDR_STATUS, {7'h00, a});
            rc(ADDR_STATUS, st_exp(1'h0, 1'h0, a), "w0 flag");
            // ones written onto clear flags must not set them
            wr(ADDR_STATUS, 8'hc0 | {7'h00, a});
            rc(ADDR_STATUS, st_exp(1'h0, 1'h0, a), "w1 clear");
        end
        // transmit: far receiver answers 1, 0, 1
        wr(ADDR_IRQ_ST, 8'hff);
        wr(ADDR_CTRL, 8'h91);
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            a = (k != 1);
            bm_u.frame(seed[7:0], a, s);
            rc(ADDR_STATUS, st_exp(1'h1, a, a), "tx ack");
            wr(ADDR_STATUS, 8'h00);
        end
        wr(ADDR_CTRL, 8'h90);
        rc(ADDR_STATUS, 8'h00, "ack_check_enable clr");
        // interrupts: raise, mask, clear
        rc(ADDR_IRQ_ST, 8'h03, "irq st");
        chk("irq off", 8'h00, {7'h00, irq});
        wr(ADDR_IRQ_MASK, 8'h01);
        chk("irq on", 8'h01, {7'h00, irq});
        wr(ADDR_IRQ_ST, 8'h01);
        rc(ADDR_IRQ_ST, 8'h02, "irq w1c");
        chk("irq clr", 8'h00, {7'h00, irq});
        wr(ADDR_IRQ_MASK, 8'h06);
        chk("irq nack", 8'h01, {7'h00, irq});
        wr(ADDR_IRQ_ST, 8'h02);
        @(posedge clk);
        cmd_done <= 1'h1;
        @(posedge clk);
        cmd_done <= 1'h0;
        #1;
        chk("cmd gated", 8'h00, {7'h00, irq});
        wr(ADDR_ADAPT, 8'h40);
        chk("cmd irq", 8'h01, {7'h00, irq});
        wr(ADDR_IRQ_ST, 8'h04);
        chk("cmd clr", 8'h00, {7'h00, irq});
        // direct pin control, then adapter takes the pins over
        // port enabled, else the pins stay released whatever is written
        wr(ADDR_ADAPT, 8'h00);
        wr(ADDR_CTRL, 8'h80);
        wr(ADDR_PIN, 8'h03);
        chk("pin drive", 8'h03, {6'h00, scl_oe, sda_oe});
        chk("pin level", 8'h00, {6'h00, pin_scl_o, pin_sda_o});
        wr(ADDR_PIN, 8'h00);
        wr(ADDR_ADAPT, 8'h80);
        wr(ADDR_PIN, 8'h03);
        chk("pin blocked", 8'h00, {6'h00, scl_oe, sda_oe});
        rc(ADDR_PIN, 8'h00, "pin reg");
        rc(ADDR_ADAPT, 8'h80, "adapter en");
        wr(ADDR_STATUS, 8'h00);
        // port enable off: the adapter alone must keep the pins driving
        wr(ADDR_CTRL, 8'h00);
        bm_u.frame(8'h5a, 1'h1, s);
        chk("adapter ack", 8'h00, {7'h00, s});
        stop_test();
    end
endmodule : i2c_ack_bit_and_adapter_enable_tb_top
`default_nettype wire

/* File: iaba_bus_model.sv */
// far-side bus master model: start, eight data bits, ack slot, stop
`default_nettype none
module iaba_bus_model #(
    parameter int PH = 4
) (
    input wire logic clk,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // lines released at time zero, pull-up gives idle high
    initial begin
        scl_o = 1'h1;
        sda_o = 1'h1;
    end
    // one bus clock phase; short so that frames stay cheap to run
    task automatic wt();
        repeat (PH) @(posedge clk);
    endtask : wt
    // ack 1 releases the line in the ack slot, seen is the wire level
    task automatic frame(input logic [7:0] b, input logic ack,
                         output logic seen);
        logic [8:0] f;
        f = {b, ack};
        sda_o <= 1'h0;
        wt();
        scl_o <= 1'h0;
        for (int i = 8; i >= 0; i--) begin
            sda_o <= f[i];
            wt();
            scl_o <= 1'h1;
            wt();
            seen = sda_i;  // end of the high phase, just before the clock falls
            scl_o <= 1'h0;
        end
        // stop: data rises while clock high
        sda_o <= 1'h0;
        wt();
        scl_o <= 1'h1;
        wt();
        sda_o <= 1'h1;
        wt();
    endtask : frame
endmodule : iaba_bus_model
`default_nettype wire

/* File: iaba_pkg.sv */
// constants, types and register map of the ack bit and adapter enable block
// Operation
// - transmitting with ack checking on, a 1 in the ack slot sets the ack bit.
// - transmitting with ack checking on, a 0 in the ack slot clears it.
// - writing 0 to the ack check enable also clears the ack bit.
// - receiving, the stored ack value is returned after each data byte.
// - a read gives the bus value when transmitting, else the software value.
// - a write of the ack bit updates the receive ack value in any mode.
// - clear-only flags take a written 0 to clear, a written 1 does nothing.
// - the ack bit resets to 0 and is readable and writable.
// - adapter enable 0 leaves the bus pins under direct software control.
// - adapter enable 1 activates the adapter and blocks direct pin control.
// - with adapter enable set the pins drive the bus as with bus enable set.
// - adapter enable and command irq enable reset to 0 and are read/write.
// - command irq enable 0 masks the command request interrupt, 1 passes it.
`default_nettype none
package iaba_pkg;
    // register offsets
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h01;
    localparam logic [7:0] ADDR_ADAPT = 8'h02;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h03;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h04;
    localparam logic [7:0] ADDR_PIN = 8'h05;
    // bus_status_flags fields
    localparam int ST_ACK = 0;
    localparam int ST_NACK = 6;
    localparam int ST_BYTE = 7;
    // bus control fields
    localparam int CTRL_ACK_CHK = 0;
    localparam int CTRL_TX_SEL = 4;
    localparam int CTRL_PORT_EN = 7;
    // reservation_adapter_control fields
    localparam int ADP_CMD_IRQ = 6;
    localparam int ADP_EN = 7;
    // interrupt status and mask fields
    localparam int IRQ_BYTE = 0;
    localparam int IRQ_NACK = 1;
    localparam int IRQ_CMD = 2;
    localparam int IRQ_W = 3;
    // direct pin control fields
    localparam int PIN_SDA = 0;
    localparam int PIN_SCL = 1;
    // reset value of every register
    localparam logic [7:0] REG_RST = 8'h00;
    // bit counter: data bits per byte before the ack slot
    localparam int BIT_CNT_W = 4;
    localparam logic [BIT_CNT_W-1:0] DATA_BITS = 4'h8;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 4'h0;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_ONE = 4'h1;
    // framing tracker states
    typedef enum logic [1:0] {SL_IDLE, SL_DATA, SL_ACK} iaba_slot_t;
endpackage : iaba_pkg
`default_nettype wire

/* File: iaba_slot_track.sv */
// bit framing tracker: finds the ack slot and samples the ack level
`default_nettype none
module iaba_slot_track
    import iaba_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic scl,
    input wire logic sda,
    output logic ack_slot,
    output logic ack_stb,
    output logic ack_val
);
    typedef struct packed {
        iaba_slot_t st;
        logic [BIT_CNT_W-1:0] bits;
        logic scl_p;
        logic sda_p;
        logic stb;
        logic val;
    } iaba_trk_t;

    iaba_trk_t q, d;
    logic scl_rise, scl_fall, start_c, stop_c;

    // line events from the previous sample
    assign scl_rise = scl & ~q.scl_p;
    assign scl_fall = ~scl & q.scl_p;
    assign start_c = scl & q.scl_p & q.sda_p & ~sda;
    assign stop_c = scl & q.scl_p & ~q.sda_p & sda;

    // next state of the tracker
    always_comb begin
        d = q;
        d.scl_p = scl;
        d.sda_p = sda;
        d.stb = 1'b0;
        if (!enable || stop_c) begin
            d.st = SL_IDLE;
        end else if (start_c) begin
            d.st = SL_DATA; // repeated start restarts framing
            d.bits = BIT_CNT_ZERO;
        end else begin
            unique case (q.st)
                SL_IDLE: begin
                end
                SL_DATA: begin
                    if (scl_rise) begin
                        d.bits = q.bits + BIT_CNT_ONE;
                    end
                    if (scl_fall && q.bits == DATA_BITS) begin
                        d.st = SL_ACK;
                    end
                end
                SL_ACK: begin
                    // sample on the rising edge of the ninth pulse
                    if (scl_rise) begin
                        d.stb = 1'b1;
                        d.val = sda;
                    end
                    if (scl_fall) begin
                        d.st = SL_DATA;
                        d.bits = BIT_CNT_ZERO;
                    end
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign ack_slot = (q.st == SL_ACK);
    assign ack_stb = q.stb;
    assign ack_val = q.val;
endmodule : iaba_slot_track
`default_nettype wire

/* File: iaba_top.sv */
// ack bit logic, adapter enable, registers and pin drive of the bus port
//
// Our own choices: the address-and-strobe port and the register addresses.
`default_nettype none
module iaba_top
    import iaba_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic CMD_DONE,
    output logic IRQ,
    input wire logic SCL_I,
    output logic SCL_O,
    output logic SCL_OE,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE
);
    typedef struct packed {
        logic ack_rx;
        logic ack_sw;
        logic ack_chk;
        logic tx_sel;
        logic port_en;
        logic adp_en;
        logic cmd_irq_en;
        logic st_byte;
        logic st_nack;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_mask;
        logic pin_scl_low;
        logic pin_sda_low;
        logic [7:0] rdata;
    } iaba_state_t;

    iaba_state_t q, d;
    logic pins_on, ack_slot, ack_stb, ack_val, capture, rx_ack_drive;
    logic wr_status, wr_ctrl, wr_adapt, wr_irq_st, wr_mask, wr_pin;
    logic [IRQ_W-1:0] irq_ev, irq_gate;
    logic ack_view;

    // pins drive when either the port or the adapter is enabled
    assign pins_on = q.port_en | q.adp_en;

    iaba_slot_track u_slot (
        .clk(CLK),
        .rst_n(RST_N),
        .enable(pins_on),
        .scl(SCL_I),
        .sda(SDA_I),
        .ack_slot(ack_slot),
        .ack_stb(ack_stb),
        .ack_val(ack_val)
    );

    // write decode
    assign wr_status = WR && ADDR == ADDR_STATUS;
    assign wr_ctrl = WR && ADDR == ADDR_CTRL;
    assign wr_adapt = WR && ADDR == ADDR_ADAPT;
    assign wr_irq_st = WR && ADDR == ADDR_IRQ_ST;
    assign wr_mask = WR && ADDR == ADDR_IRQ_MASK;
    assign wr_pin = WR && ADDR == ADDR_PIN;

    // bus ack is only latched while transmitting with checking on
    assign capture = ack_stb & q.tx_sel & q.ack_chk;
    // visible ack bit depends on direction
    assign ack_view = q.tx_sel ? q.ack_rx : q.ack_sw;

    // events for the sticky interrupt status
    always_comb begin
        irq_ev = '0;
        irq_ev[IRQ_BYTE] = ack_stb;
        irq_ev[IRQ_NACK] = ack_stb & ack_val & q.tx_sel;
        irq_ev[IRQ_CMD] = CMD_DONE;
    end

    // next state of all registers
    always_comb begin
        d = q;
        d.rdata = REG_RST; // read data stand one cycle only
        // register writes
        if (wr_status) begin
            d.ack_sw = WDATA[ST_ACK];
            // clear-only flags: a 0 clears, a 1 is ignored
            if (!WDATA[ST_BYTE]) d.st_byte = 1'b0;
            if (!WDATA[ST_NACK]) d.st_nack = 1'b0;
        end
        if (wr_ctrl) begin
            d.ack_chk = WDATA[CTRL_ACK_CHK];
            d.tx_sel = WDATA[CTRL_TX_SEL];
            d.port_en = WDATA[CTRL_PORT_EN];
            if (!WDATA[CTRL_ACK_CHK]) d.ack_rx = 1'b0;
        end
        if (wr_adapt) begin
            d.adp_en = WDATA[ADP_EN];
            d.cmd_irq_en = WDATA[ADP_CMD_IRQ];
        end
        // adapter owns the port, so direct pin writes are dropped
        if (wr_pin && !q.adp_en) begin
            d.pin_scl_low = WDATA[PIN_SCL];
            d.pin_sda_low = WDATA[PIN_SDA];
        end
        if (wr_irq_st) begin
            d.irq_st = q.irq_st & ~WDATA[IRQ_W-1:0];
        end
        if (wr_mask) begin
            d.irq_mask = WDATA[IRQ_W-1:0];
        end
        // hardware events last so a set beats a same-cycle clear
        if (capture) begin
            d.ack_rx = ack_val;
        end
        if (ack_stb) begin
            d.st_byte = 1'b1;
        end
        if (irq_ev[IRQ_NACK]) begin
            d.st_nack = 1'b1;
        end
        d.irq_st = d.irq_st | irq_ev;
        // read mux, answered in the following cycle
        if (RD) begin
            unique case (ADDR)
                ADDR_STATUS: begin
                    d.rdata[ST_ACK] = ack_view;
                    d.rdata[ST_NACK] = q.st_nack;
                    d.rdata[ST_BYTE] = q.st_byte;
                end
                ADDR_CTRL: begin
                    d.rdata[CTRL_ACK_CHK] = q.ack_chk;
                    d.rdata[CTRL_TX_SEL] = q.tx_sel;
                    d.rdata[CTRL_PORT_EN] = q.port_en;
                end
                ADDR_ADAPT: begin
                    d.rdata[ADP_EN] = q.adp_en;
                    d.rdata[ADP_CMD_IRQ] = q.cmd_irq_en;
                end
                ADDR_IRQ_ST: d.rdata[IRQ_W-1:0] = q.irq_st;
                ADDR_IRQ_MASK: d.rdata[IRQ_W-1:0] = q.irq_mask;
                ADDR_PIN: begin
                    d.rdata[PIN_SCL] = q.pin_scl_low;
                    d.rdata[PIN_SDA] = q.pin_sda_low;
                end
                default: d.rdata = REG_RST; // unmapped reads as zero
            endcase
        end
    end

    // all registers clear on reset, ack bit and adapter bits included
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // receiving: pull data low in the ninth pulse when the ack value is 0
    assign rx_ack_drive = ack_slot & ~q.tx_sel & ~q.ack_sw;

    // open-drain pins only ever pull low
    assign SCL_O = 1'b0;
    assign SDA_O = 1'b0;
    assign SCL_OE = pins_on & ~q.adp_en & q.pin_scl_low;
    assign SDA_OE = pins_on & ((~q.adp_en & q.pin_sda_low) | rx_ack_drive);

    // command request only reaches the line with its enable set
    always_comb begin
        irq_gate = q.irq_mask;
        irq_gate[IRQ_CMD] = q.irq_mask[IRQ_CMD] & q.cmd_irq_en;
    end
    assign IRQ = |(q.irq_st & irq_gate);
    assign RDATA = q.rdata;

    // checks on the ack bit and the byte flag
    a_ack_set_one: assert property (@(posedge CLK) disable iff (!RST_N)
        capture && ack_val |=> q.ack_rx && q.irq_st[IRQ_BYTE])
        else $error("ack bit not set by a received 1");
    a_ack_clr_zero: assert property (@(posedge CLK) disable iff (!RST_N)
        capture && !ack_val |=> !q.ack_rx)
        else $error("ack bit not cleared by a received 0");
    a_chk_off_clr: assert property (@(posedge CLK) disable iff (!RST_N)
        wr_ctrl && !WDATA[CTRL_ACK_CHK] && !capture |=>
        !q.ack_rx && !q.ack_chk)
        else $error("ack check disable left ack bit set");
    a_ack_read_mux: assert property (@(posedge CLK) disable iff (!RST_N)
        RD && ADDR == ADDR_STATUS |=>
        RDATA[ST_ACK] == ($past(q.tx_sel) ? $past(q.ack_rx) : $past(q.ack_sw)))
        else $error("ack bit read from wrong source");
    a_ack_write: assert property (@(posedge CLK) disable iff (!RST_N)
        wr_status |=> q.ack_sw == $past(WDATA[ST_ACK]) ##1 1'b1)
        else $error("ack write not stored");
    a_flag_clr_only: assert property (@(posedge CLK) disable iff (!RST_N)
        wr_status && WDATA[ST_BYTE] && !q.st_byte && !ack_stb |=> !q.st_byte)
        else $error("writing 1 set a clear-only flag");
    // checks on pins and adapter
    a_rx_ack_drive: assert property (@(posedge CLK) disable iff (!RST_N)
        ack_slot && pins_on && !q.tx_sel && !q.ack_sw |-> SDA_OE)
        else $error("receive ack 0 not driven in ninth pulse");
    a_rx_ack_high: assert property (@(posedge CLK) disable iff (!RST_N)
        ack_slot && !q.tx_sel && q.ack_sw && (q.adp_en || !q.pin_sda_low)
        |-> !SDA_OE)
        else $error("receive ack 1 pulled data low");
    a_pins_idle: assert property (@(posedge CLK) disable iff (!RST_N)
        !q.port_en && !q.adp_en |-> !SDA_OE && !SCL_OE)
        else $error("pins driven while port disabled");
    a_direct_block: assert property (@(posedge CLK) disable iff (!RST_N)
        wr_pin && q.adp_en |=> $stable(q.pin_sda_low) && $stable(q.pin_scl_low))
        else $error("direct pin write passed with adapter on");
    a_cmd_irq_gate: assert property (@(posedge CLK) disable iff (!RST_N)
        q.irq_st == (3'h1 << IRQ_CMD) && q.irq_mask[IRQ_CMD]
        |-> IRQ == q.cmd_irq_en)
        else $error("command interrupt enable not honoured");
endmodule : iaba_top
`default_nettype wire
